// file: rtl/ssr_defs.svh
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

// ==========================================================
// Source selector codes
`define SSR_SEL_KEYPAD      3'h0
`define SSR_SEL_INTERNAL    3'h1
`define SSR_SEL_AIN1        3'h2
`define SSR_SEL_AIN2        3'h3
`define SSR_SEL_PRESET      3'h4
`define SSR_SEL_COMM        3'h5
`define SSR_SEL_DEFAULT     3'h2

// ==========================================================
// Digital input function codes
`define SSR_FUNC_PURGE      5'h01
`define SSR_FUNC_ACCEL2     5'h03
`define SSR_FUNC_PRESET     5'h08
`define SSR_FUNC_MOP_UP     5'h10
`define SSR_FUNC_MOP_DN     5'h11

// ==========================================================
// Setting defaults and limits (0.01 Hz, 0.01 s, percent)
`define SSR_PURGE_DEF       16'h01F4
`define SSR_INTERNAL_DEF    16'h1770
`define SSR_PRESET0_DEF     16'h0000
`define SSR_PRESET1_DEF     16'h01F4
`define SSR_PRESET2_DEF     16'h03E8
`define SSR_PRESET3_DEF     16'h07D0
`define SSR_ACCEL2_DEF      16'h0BB8
`define SSR_TRIM_HI_DEF     16'h1770
`define SSR_FREQ_MAX        16'h7D00
`define SSR_DECEL_MIN       16'h0001
`define SSR_SCURVE_DEF      7'h14
`define SSR_SCURVE_MAX      7'h64

// ==========================================================
// Timing
`define SSR_CLK_NS          10
`define SSR_TICK_NS         10000
`define SSR_TICK_CYC        (`SSR_TICK_NS / `SSR_CLK_NS)
`define SSR_TICKS_PER_S     (1000000000 / `SSR_TICK_NS)
`define SSR_RAMP_SCALE      (`SSR_TICKS_PER_S / 100)
`define SSR_KEY_STEP_TICKS  100

`endif

// file: rtl/ssr_pkg.sv
`default_nettype none

package ssr_pkg;

	// ==========================================================
	// Scalar types
	typedef logic [15:0] ssr_freq_t;	// Frequency, 0.01 Hz units
	typedef logic [15:0] ssr_time_t;	// Ramp time, 0.01 s units

	// Fixed-frequency settings
	typedef struct packed {
		ssr_freq_t purge;
		ssr_freq_t preset3;
		ssr_freq_t preset2;
		ssr_freq_t preset1;
		ssr_freq_t preset0;
	} ssr_fixed_cfg_t;

	// Both ramp sets and the shaping amount
	typedef struct packed {
		ssr_time_t   accel1;
		ssr_time_t   decel1;
		ssr_time_t   accel2;
		ssr_time_t   decel2;
		logic [6:0]  s_pct;
	} ssr_ramp_cfg_t;

	// Ramp direction
	typedef enum logic [1:0] {RS_HOLD, RS_UP, RS_DOWN} ssr_ramp_st_t;

	// Internal frequency editing
	typedef enum logic {ED_IDLE, ED_EDIT} ssr_edit_st_t;

endpackage : ssr_pkg

`default_nettype wire

// file: rtl/ssr_tick_div.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Enable divider: one-cycle pulse every PERIOD enabled cycles
module ssr_tick_div #(
	parameter int unsigned PERIOD = 1000
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic en,
	output logic      tick
);

	localparam int unsigned CW = $clog2(PERIOD);

	// Refuse periods that cannot make a pulse train
	generate
		if (PERIOD < 2)
		begin : g_bad_period
			$error("ssr_tick_div: PERIOD must be at least 2");
		end
	endgenerate

	logic [CW-1:0] cnt_q;	// Cycles since last pulse

	// Counter wraps at PERIOD-1 and pulses on the wrap
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else if (en)
			cnt_q <= (cnt_q == CW'(PERIOD - 1)) ? '0 : cnt_q + 1'b1;
	end

	assign tick = en && (cnt_q == CW'(PERIOD - 1));

endmodule : ssr_tick_div

`default_nettype wire

// file: rtl/ssr_top.sv
// Functional notes
// - Network local mode uses alternate selector
// - Code 0 takes keypad up/down reference
// - Codes 2/3 take analog input one/two
// - Code 4 takes preset table via inputs
// - Code 5 takes communication port reference
// - Purge input overrides every other command
// - Primary code 1 uses internal frequency
// - Program-mode keys edit live; Enter stores
// - Escape restores original value, ramped normally
// - Up/down inputs adjust internal frequency when primary code is 1
// - Two preset inputs pick one of four
// - Presets two/three use second ramp set
// - Second-ramp input overrides preset ramp choice
// - Preset zero only with selector code 4
// - Second accel: rate is max over time
// - Second decel: rate is max over time
// - S-curve adds percent time, half each end
// - Positive trim bounded by trim-high limit
`timescale 1ns/1ps
`default_nettype none
`include "ssr_defs.svh"

module ssr_top #(
	parameter int unsigned TICK_CYC = `SSR_TICK_CYC
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   net_control,
	input  wire logic                   net_local,
	input  wire logic [2:0]             primary_speed_ref_select,
	input  wire logic [2:0]             alt_speed_ref_select,
	input  wire logic [4:0]             digital_input_one_function,
	input  wire logic [4:0]             digital_input_two_function,
	input  wire logic [1:0]             din_pin,
	input  wire logic                   key_up_pin,
	input  wire logic                   key_down_pin,
	input  wire logic                   key_enter_pin,
	input  wire logic                   key_esc_pin,
	input  wire logic                   program_mode,
	input  wire ssr_pkg::ssr_freq_t     ain_one_freq,
	input  wire ssr_pkg::ssr_freq_t     ain_two_freq,
	input  wire ssr_pkg::ssr_freq_t     comm_freq,
	input  wire ssr_pkg::ssr_freq_t     internal_freq_setting,
	input  wire ssr_pkg::ssr_freq_t     max_freq,
	input  wire ssr_pkg::ssr_fixed_cfg_t fixed_cfg,
	input  wire ssr_pkg::ssr_ramp_cfg_t ramp_cfg,
	input  wire logic                   pid_trim_enable,
	input  wire logic signed [16:0]     pid_trim_in,
	input  wire ssr_pkg::ssr_freq_t     pid_trim_high_limit,
	output ssr_pkg::ssr_freq_t          freq_out,
	output ssr_pkg::ssr_freq_t          target_freq,
	output logic                        ramp_second_set,
	output logic                        purge_active,
	output logic                        preset_active,
	output logic                        nv_store,
	output ssr_pkg::ssr_freq_t          nv_value,
	output ssr_pkg::ssr_freq_t          internal_freq_live,
	output logic                        at_speed
);

	localparam int unsigned RAMP_SCALE = `SSR_RAMP_SCALE;

	generate
		if (TICK_CYC < 2)
		begin : g_bad_tick
			$error("ssr_top: TICK_CYC must be at least 2");
		end
	endgenerate

	// ==========================================================
	// Pin synchronisers
	logic [5:0] pin_meta_q;	// First stage, read only by second
	logic [5:0] pin_q;	// Synchronised pins
	logic [1:0] key_prev_q;	// Enter, Esc history for edges

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_meta_q <= 6'h00;
			pin_q      <= 6'h00;
			key_prev_q <= 2'h0;
		end
		else
		begin
			pin_meta_q <= {key_esc_pin, key_enter_pin, key_down_pin,
				key_up_pin, din_pin};
			pin_q      <= pin_meta_q;
			key_prev_q <= pin_q[5:4];
		end
	end

	wire din1      = pin_q[0];
	wire din2      = pin_q[1];
	wire key_up    = pin_q[2];
	wire key_down  = pin_q[3];
	wire enter_hit = pin_q[4] && !key_prev_q[0];
	wire esc_hit   = pin_q[5] && !key_prev_q[1];

	// ==========================================================
	// Tick dividers: ramp tick and slower key repeat tick
	logic ramp_tick;	// Control tick for the ramp
	logic key_tick;	// Repeat rate for up/down adjustment

	ssr_tick_div #(.PERIOD(TICK_CYC)) u_ramp_tick (
		.core_clk (core_clk),
		.rst      (rst),
		.en       (1'b1),
		.tick     (ramp_tick)
	);

	ssr_tick_div #(.PERIOD(`SSR_KEY_STEP_TICKS)) u_key_tick (
		.core_clk (core_clk),
		.rst      (rst),
		.en       (ramp_tick),
		.tick     (key_tick)
	);

	// ==========================================================
	// Digital input functions
	function automatic logic fn_hit(input logic [4:0] f1,
		input logic [4:0] f2, input logic [4:0] code);
		fn_hit = (f1 == code && din1) || (f2 == code && din2);
	endfunction : fn_hit

	wire [4:0] f1 = digital_input_one_function;
	wire [4:0] f2 = digital_input_two_function;
	wire purge_in  = fn_hit(f1, f2, `SSR_FUNC_PURGE);
	wire accel2_in = fn_hit(f1, f2, `SSR_FUNC_ACCEL2);
	wire mop_up    = fn_hit(f1, f2, `SSR_FUNC_MOP_UP);
	wire mop_dn    = fn_hit(f1, f2, `SSR_FUNC_MOP_DN);
	// Preset index bit per input, only when configured as preset
	wire [1:0] preset_idx = {f2 == `SSR_FUNC_PRESET && din2,
		f1 == `SSR_FUNC_PRESET && din1};

	// ==========================================================
	// Source selection
	// Illegal selector codes fall back to the default source
	wire [2:0] sel_raw = (net_control && net_local) ?
		alt_speed_ref_select : primary_speed_ref_select;
	wire [2:0] sel = (sel_raw > `SSR_SEL_COMM) ? `SSR_SEL_DEFAULT :
		sel_raw;
	wire sel_preset   = (sel == `SSR_SEL_PRESET);
	wire prim_internal = (primary_speed_ref_select == `SSR_SEL_INTERNAL);

	// Preset zero needs the preset code; others override on their own
	wire preset_ovr = (preset_idx != 2'h0) || sel_preset;

	ssr_pkg::ssr_freq_t preset_f;	// Selected preset frequency
	ssr_pkg::ssr_freq_t keypad_q;	// Keypad up/down reference
	ssr_pkg::ssr_freq_t live_q;	// Internal frequency, live copy
	ssr_pkg::ssr_freq_t saved_q;	// Internal frequency, stored copy

	assign preset_f =
		(preset_idx == 2'h3) ? fixed_cfg.preset3 :
		(preset_idx == 2'h2) ? fixed_cfg.preset2 :
		(preset_idx == 2'h1) ? fixed_cfg.preset1 :
		fixed_cfg.preset0;

	ssr_pkg::ssr_freq_t base_f;	// Reference before trim
	assign base_f =
		(sel == `SSR_SEL_KEYPAD)   ? keypad_q :
		(sel == `SSR_SEL_INTERNAL) ? live_q :
		(sel == `SSR_SEL_AIN1)     ? ain_one_freq :
		(sel == `SSR_SEL_AIN2)     ? ain_two_freq :
		(sel == `SSR_SEL_PRESET)   ? preset_f :
		comm_freq;

	// ==========================================================
	// Trim: positive part bounded, sum kept within 0..max
	wire signed [16:0] trim_hi = $signed({1'b0, pid_trim_high_limit});
	wire signed [16:0] trim_used = !pid_trim_enable ? 17'sh00000 :
		(pid_trim_in > trim_hi) ? trim_hi : pid_trim_in;
	wire signed [17:0] trim_sum = $signed({2'b00, base_f}) +
		18'(trim_used);
	ssr_pkg::ssr_freq_t trimmed_f;
	// Negative sums floor at zero, carries past 16 bits saturate
	assign trimmed_f = trim_sum[17] ? 16'h0000 :
		trim_sum[16] ? 16'hFFFF : trim_sum[15:0];

	// Purge over preset over selected source
	ssr_pkg::ssr_freq_t cmd_raw;
	assign cmd_raw = purge_in ? fixed_cfg.purge :
		preset_ovr ? preset_f : trimmed_f;
	ssr_pkg::ssr_freq_t cmd_f;
	assign cmd_f = (cmd_raw > max_freq) ? max_freq : cmd_raw;

	// ==========================================================
	// Ramp set choice
	// The dedicated input beats the preset table's choice
	wire use_second = accel2_in ||
		(preset_ovr && !purge_in && preset_idx[1]);
	wire [15:0] accel_t = use_second ? ramp_cfg.accel2 : ramp_cfg.accel1;
	wire [15:0] decel_raw = use_second ? ramp_cfg.decel2 :
		ramp_cfg.decel1;
	// A zero deceleration time is outside the legal range
	wire [15:0] decel_t = (decel_raw < `SSR_DECEL_MIN) ? `SSR_DECEL_MIN :
		decel_raw;
	wire [6:0] s_pct = (ramp_cfg.s_pct > `SSR_SCURVE_MAX) ?
		`SSR_SCURVE_MAX : ramp_cfg.s_pct;

	// ==========================================================
	// Ramp generator
	ssr_pkg::ssr_freq_t freq_q;	// Ramp output
	ssr_pkg::ssr_freq_t target_q;	// Registered target
	ssr_pkg::ssr_freq_t start_q;	// Output where this ramp began
	ssr_pkg::ssr_ramp_st_t ramp_st;	// Direction this cycle
	logic [27:0] acc_q;	// Fractional step accumulator

	always_comb
	begin
		ramp_st = ssr_pkg::RS_HOLD;
		case (1'b1)
			(freq_q < target_q): ramp_st = ssr_pkg::RS_UP;
			(freq_q > target_q): ramp_st = ssr_pkg::RS_DOWN;
			default:             ramp_st = ssr_pkg::RS_HOLD;
		endcase
	end

	wire [15:0] rate_t = (ramp_st == ssr_pkg::RS_UP) ? accel_t :
		decel_t;
	wire [15:0] d_start = (freq_q > start_q) ? freq_q - start_q :
		start_q - freq_q;
	wire [15:0] d_end = (freq_q > target_q) ? freq_q - target_q :
		target_q - freq_q;
	// Shaped zones: S/200 of full scale at each end of the ramp
	wire [22:0] zone_prod = max_freq * s_pct;
	wire [15:0] zone = 16'(zone_prod / 23'd200);
	wire shaped = (s_pct != 7'h00) &&
		((d_start < zone) || (d_end < zone));
	// Half rate in a shaped zone, so each zone costs its own length again
	wire [27:0] thresh_base = 28'(rate_t * RAMP_SCALE);
	wire [27:0] thresh = shaped ? {thresh_base[26:0], 1'b0} :
		thresh_base;
	wire [27:0] acc_sum = acc_q + 28'(max_freq);
	wire step_now = ramp_tick && (acc_sum >= thresh);
	// Surplus is capped so a ramp faster than one step a tick cannot wrap
	wire [27:0] acc_left = (acc_sum - thresh > thresh) ? thresh :
		acc_sum - thresh;

	// One step of 0.01 Hz per tick at most; zero accel time jumps at once
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			freq_q   <= 16'h0000;
			target_q <= 16'h0000;
			start_q  <= 16'h0000;
			acc_q    <= 28'h0000000;
		end
		else
		begin
			target_q <= cmd_f;
			// A new target restarts the shaping and the fraction
			if (cmd_f != target_q)
			begin
				start_q <= freq_q;
				acc_q   <= 28'h0000000;
			end
			else if (ramp_tick)
			begin
				case (ramp_st)
					ssr_pkg::RS_UP, ssr_pkg::RS_DOWN:
					begin
						if (rate_t == 16'h0000)
							freq_q <= target_q;
						else if (step_now)
						begin
							freq_q <= (ramp_st == ssr_pkg::RS_UP) ?
								freq_q + 1'b1 : freq_q - 1'b1;
							acc_q  <= acc_left;
						end
						else
							acc_q <= acc_sum;
					end
					default:
					begin
						acc_q   <= 28'h0000000;
						start_q <= freq_q;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Keypad reference and internal frequency editing
	ssr_pkg::ssr_edit_st_t edit_q;	// Unstored edit pending
	logic loaded_q;	// Stored value fetched after reset
	logic nv_store_q;	// Store pulse
	ssr_pkg::ssr_freq_t nv_value_q;	// Value handed to storage

	wire edit_keys = program_mode && (sel == `SSR_SEL_INTERNAL);
	wire live_up = key_tick && ((edit_keys && key_up) ||
		(prim_internal && mop_up));
	wire live_dn = key_tick && ((edit_keys && key_down) ||
		(prim_internal && mop_dn));
	wire kp_up = key_tick && (sel == `SSR_SEL_KEYPAD) && key_up;
	wire kp_dn = key_tick && (sel == `SSR_SEL_KEYPAD) && key_down;

	// Keypad reference moves one unit per repeat tick
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			keypad_q <= 16'h0000;
		else if (kp_up && keypad_q < max_freq)
			keypad_q <= keypad_q + 1'b1;
		else if (kp_dn && keypad_q != 16'h0000)
			keypad_q <= keypad_q - 1'b1;
	end

	// Escape beats a key step in the same cycle
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			live_q     <= `SSR_INTERNAL_DEF;
			saved_q    <= `SSR_INTERNAL_DEF;
			loaded_q   <= 1'b0;
			edit_q     <= ssr_pkg::ED_IDLE;
			nv_store_q <= 1'b0;
			nv_value_q <= 16'h0000;
		end
		else
		begin
			nv_store_q <= 1'b0;
			if (!loaded_q)
			begin
				live_q   <= internal_freq_setting;
				saved_q  <= internal_freq_setting;
				loaded_q <= 1'b1;
			end
			else
			begin
				case (edit_q)
					ssr_pkg::ED_EDIT:
					begin
						if (esc_hit)
						begin
							live_q <= saved_q;
							edit_q <= ssr_pkg::ED_IDLE;
						end
						else if (enter_hit)
						begin
							saved_q    <= live_q;
							nv_value_q <= live_q;
							nv_store_q <= 1'b1;
							edit_q     <= ssr_pkg::ED_IDLE;
						end
					end
					default:
					begin
						if (edit_keys && (live_up || live_dn))
							edit_q <= ssr_pkg::ED_EDIT;
					end
				endcase
				if (!(edit_q == ssr_pkg::ED_EDIT && esc_hit))
				begin
					if (live_up && live_q < max_freq)
						live_q <= live_q + 1'b1;
					else if (live_dn && live_q != 16'h0000)
						live_q <= live_q - 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Outputs
	logic [2:0] flags_q;	// Registered status flags

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			flags_q <= 3'h0;
		else
			flags_q <= {use_second, purge_in, preset_ovr && !purge_in};
	end

	assign freq_out           = freq_q;
	assign target_freq        = target_q;
	assign ramp_second_set    = flags_q[2];
	assign purge_active       = flags_q[1];
	assign preset_active      = flags_q[0];
	assign nv_store           = nv_store_q;
	assign nv_value           = nv_value_q;
	assign internal_freq_live = live_q;
	assign at_speed           = (freq_q == target_q);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_PURGE_WINS: assert property (
		purge_in && fixed_cfg.purge <= max_freq |=>
			target_freq == $past(fixed_cfg.purge))
		else $error("purge did not override the command");

	AST_ALT_SOURCE: assert property (
		net_control && net_local && !purge_in && !preset_ovr &&
		!pid_trim_enable && alt_speed_ref_select == `SSR_SEL_AIN2 &&
		ain_two_freq <= max_freq |=> target_freq == $past(ain_two_freq))
		else $error("alternate selector not honoured");

	AST_PRESET_ZERO: assert property (
		preset_idx == 2'h0 && !sel_preset && !purge_in |=> !preset_active)
		else $error("preset zero used without preset code");

	AST_SECOND_SET: assert property (
		accel2_in && preset_idx == 2'h1 |=> ramp_second_set)
		else $error("second ramp input did not override preset");

	AST_PRESET_SET: assert property (
		!accel2_in && !purge_in && preset_idx != 2'h0 |=>
			ramp_second_set == $past(preset_idx[1]))
		else $error("preset ramp set wrong");

	AST_ONE_STEP: assert property (
		$past(rate_t) != 16'h0000 && $past(cmd_f) == $past(target_q) |->
			(freq_q - $past(freq_q) <= 16'h0001) ||
			($past(freq_q) - freq_q <= 16'h0001))
		else $error("ramp moved more than one step");

	AST_TICK_ONLY: assert property (
		!ramp_tick |=> $stable(freq_out))
		else $error("ramp moved without a tick");

	AST_TRIM_BOUND: assert property (
		pid_trim_enable && !purge_in && !preset_ovr && pid_trim_in > 0 |->
			trim_sum <= $signed({2'b00, base_f}) +
			$signed({2'b00, pid_trim_high_limit}))
		else $error("trim above high limit");

	AST_ENTER_STORE: assert property (
		edit_q == ssr_pkg::ED_EDIT && enter_hit && !esc_hit |=>
			nv_store && nv_value == saved_q ##1 !nv_store)
		else $error("enter did not store the edited value");

	AST_ESC_RESTORE: assert property (
		edit_q == ssr_pkg::ED_EDIT && esc_hit |=>
			internal_freq_live == $past(saved_q) &&
			edit_q == ssr_pkg::ED_IDLE)
		else $error("escape did not restore the value");

	COV_PURGE: cover property (purge_in ##1 purge_active);
	COV_RAMP_UP: cover property (ramp_st == ssr_pkg::RS_UP ##1 ramp_tick);
	COV_ESC: cover property (edit_q == ssr_pkg::ED_EDIT && esc_hit);
	COV_PRESET3: cover property (preset_idx == 2'h3 ##1 ramp_second_set);

endmodule : ssr_top

`default_nettype wire

// file: verif/ssr_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Terminal block and keypad seen from outside the drive
module ssr_far_model (
	input  wire logic       core_clk,
	input  wire logic [1:0] din_cmd,
	input  wire logic [3:0] key_cmd,
	output logic [1:0]      din_pin,
	output logic            key_up_pin,
	output logic            key_down_pin,
	output logic            key_enter_pin,
	output logic            key_esc_pin
);
	// Contacts change away from the sampling edge so sync flops see clean levels
	always @(negedge core_clk)
	begin
		din_pin       <= din_cmd;	// Bit 0 is input one
		key_up_pin    <= key_cmd[3];
		key_down_pin  <= key_cmd[2];
		key_enter_pin <= key_cmd[1];	// Held key, edge taken inside
		key_esc_pin   <= key_cmd[0];
	end
endmodule : ssr_far_model

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench, short ramp tick to keep the run brief
module tb_top;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic nctl = 1'b0, nloc = 1'b0, trim_en = 1'b0, pmode = 1'b0;
	logic [2:0] psel = 3'h0, asel = 3'h0;	// Selectors
	logic [4:0] f1 = 5'h00, f2 = 5'h00;	// Input functions
	logic [1:0] din_cmd = 2'h0;
	logic [3:0] key_cmd = 4'h0;	// Up, down, enter, esc
	logic signed [16:0] trim = 17'sh00000;
	ssr_pkg::ssr_freq_t ain1 = 16'h0457, ain2 = 16'h08AE, comm = 16'h0D05;
	ssr_pkg::ssr_freq_t thi = 16'h00C8, f0;
	ssr_pkg::ssr_fixed_cfg_t fx = {16'h0100, 16'h07D0, 16'h03E8, 16'h01F4, 16'h0032};
	ssr_pkg::ssr_ramp_cfg_t rc = {16'h0000, 16'h0001, 16'h0000, 16'h0001, 7'h00};
	ssr_pkg::ssr_freq_t fo, tgt, nvv, live;
	logic sec, purg, pre, nvs, ats;
	logic [1:0] dpin;
	logic ku, kd, ke, kx;
	int bad_count = 0, tests_run = 0, cycles = 0;
	ssr_pkg::ssr_freq_t exp_sel [6];

	always #5 core_clk = ~core_clk;

	ssr_far_model u_far (.core_clk(core_clk), .din_cmd(din_cmd), .key_cmd(key_cmd),
		.din_pin(dpin), .key_up_pin(ku), .key_down_pin(kd),
		.key_enter_pin(ke), .key_esc_pin(kx));

	ssr_top #(.TICK_CYC(4)) u_dut (.core_clk(core_clk), .rst(rst),
		.net_control(nctl), .net_local(nloc),
		.primary_speed_ref_select(psel), .alt_speed_ref_select(asel),
		.digital_input_one_function(f1), .digital_input_two_function(f2),
		.din_pin(dpin), .key_up_pin(ku), .key_down_pin(kd),
		.key_enter_pin(ke), .key_esc_pin(kx), .program_mode(pmode),
		.ain_one_freq(ain1), .ain_two_freq(ain2), .comm_freq(comm),
		.internal_freq_setting(16'h0BB8), .max_freq(16'h7D00),
		.fixed_cfg(fx), .ramp_cfg(rc), .pid_trim_enable(trim_en),
		.pid_trim_in(trim), .pid_trim_high_limit(thi),
		.freq_out(fo), .target_freq(tgt), .ramp_second_set(sec),
		.purge_active(purg), .preset_active(pre), .nv_store(nvs),
		.nv_value(nvv), .internal_freq_live(live), .at_speed(ats));

	// ==========================================================
	// Comparison and timing helpers
	task automatic chk16(input string what, input ssr_pkg::ssr_freq_t e,
		input ssr_pkg::ssr_freq_t g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : chk16
	task automatic chk1(input string what, input logic e, input logic g);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", what, e, g);
		end
	endtask : chk1
	// Pins need two sync flops plus the target register, so wait four
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task automatic end_of_test;
		$display("Counts: %0d compared, %0d mismatched", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	// Hang guard, a few thousand cycles is ample for this sequence
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			bad_count++;
			end_of_test();
		end
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		exp_sel = '{16'h0000, 16'h0BB8, 16'h0457, 16'h08AE, 16'h0032, 16'h0D05};
		cyc(1);
		chk16("live in reset", 16'h1770, live);
		cyc(2);
		rst = 1'b0;
		cyc(2);
		chk16("live loaded", 16'h0BB8, live);
		// Ramp sets chosen by preset inputs, zero accel jumps on a tick
		f1 = 5'h08;
		f2 = 5'h08;
		din_cmd = 2'h3;
		cyc(4);
		chk16("preset3", 16'h07D0, tgt);
		chk1("second set p3", 1'b1, sec);
		cyc(12);
		chk16("accel jump", 16'h07D0, fo);
		chk1("at speed", 1'b1, ats);
		din_cmd = 2'h2;
		cyc(4);
		chk16("preset2", 16'h03E8, tgt);
		f0 = fo;
		cyc(40);
		chk1("decel one per tick", 1'b1, (f0 - fo) >= 16'h0008 && (f0 - fo) <= 16'h000A);
		f2 = 5'h03;
		din_cmd = 2'h3;
		cyc(4);
		chk16("preset1", 16'h01F4, tgt);
		chk1("accel2 input", 1'b1, sec);
		f2 = 5'h08;
		din_cmd = 2'h1;
		cyc(4);
		chk1("first set p1", 1'b0, sec);
		f2 = 5'h01;
		din_cmd = 2'h3;
		cyc(4);
		chk16("purge", 16'h0100, tgt);
		chk1("purge flag", 1'b1, purg);
		chk1("preset yields", 1'b0, pre);
		din_cmd = 2'h0;
		f1 = 5'h00;
		f2 = 5'h00;
		$display("test ramp and overrides done");
		// Selector codes 0 to 5 in turn
		for (int i = 0; i < 6; i++)
		begin
			psel = i[2:0];
			cyc(4);
			chk16("selector", exp_sel[i], tgt);
			chk1("preset0 flag", i == 4, pre);
		end
		nctl = 1'b1;
		nloc = 1'b1;
		asel = 3'h3;
		cyc(4);
		chk16("alt selector", 16'h08AE, tgt);
		nloc = 1'b0;
		cyc(4);
		chk16("primary kept", 16'h0D05, tgt);
		nctl = 1'b0;
		$display("test selectors done");
		// Trim cap on the selected source
		psel = 3'h2;
		trim_en = 1'b1;
		trim = 17'sh001F4;
		cyc(4);
		chk16("trim capped", 16'h051F, tgt);
		trim = -17'sh0012C;
		cyc(4);
		chk16("trim negative", 16'h032B, tgt);
		trim_en = 1'b0;
		$display("test trim done");
		// Live edit, store on enter, restore on escape
		psel = 3'h1;
		pmode = 1'b1;
		key_cmd = 4'h8;
		cyc(420);
		key_cmd = 4'h0;
		cyc(4);
		chk1("live raised", 1'b1, live > 16'h0BB8);
		key_cmd = 4'h2;
		f0 = 16'h0000;
		for (int i = 0; i < 20 && f0 == 16'h0000; i++)
		begin
			cyc(1);
			if (nvs === 1'b1)
				f0 = nvv;
		end
		key_cmd = 4'h0;
		chk16("stored value", live, f0);
		key_cmd = 4'h8;
		cyc(420);
		key_cmd = 4'h1;
		cyc(6);
		key_cmd = 4'h0;
		chk16("escape restore", f0, live);
		chk16("target follows", f0, tgt);
		$display("test keypad edit done");
		// Up/down inputs move the internal frequency
		pmode = 1'b0;
		f1 = 5'h10;
		din_cmd = 2'h1;
		f0 = live;
		cyc(420);
		chk1("mop up", 1'b1, live > f0);
		f0 = live;
		f1 = 5'h11;
		cyc(420);
		chk1("mop down", 1'b1, live < f0);
		din_cmd = 2'h0;
		f1 = 5'h00;
		$display("test up/down inputs done");
		// Shaped ramp steps at half the plain rate near its ends
		rc = {16'h0064, 16'h0001, 16'h0000, 16'h0001, 7'h14};
		psel = 3'h5;
		cyc(2);
		f0 = fo;
		cyc(160);
		f0 = fo - f0;
		chk1("s rate", 1'b1, f0 >= 16'h0005 && f0 <= 16'h0007);
		rc.s_pct = 7'h00;
		f0 = fo;
		cyc(160);
		f0 = fo - f0;
		chk1("plain rate", 1'b1, f0 >= 16'h000C && f0 <= 16'h000E);
		$display("test s-curve done");
		// Keypad code: a held up key raises the keypad reference
		psel = 3'h0;
		key_cmd = 4'h8;
		cyc(420);
		key_cmd = 4'h0;
		cyc(4);
		chk1("keypad up", 1'b1, tgt > 16'h0000 && tgt <= 16'h0002);
		$display("test keypad reference done");
		end_of_test();
	end
endmodule : tb_top

`default_nettype wire
